// File: design/sal_pkg.sv
// Constants, state types and address helper for the strap latch block.
// Assumes the importing modules share one two-wire address space.
package sal_pkg;
    localparam int        STRAP_W         = 4;         // Number of strap pins
    localparam int        ADDR_W          = 7;         // Seven-bit bus address
    localparam logic [6:0] BASE_ADDR      = 7'h18;     // Address at strap value zero
    localparam logic [7:0] TEST_WR_BYTE   = 8'h30;     // Fixed write byte in test case
    localparam logic [1:0] SETTLE_CYC     = 2'h3;      // Edges before pins are trusted
    localparam logic [3:0] BYTE_BITS      = 4'h8;      // Bits per byte on the wire
    localparam logic [2:0] LAST_BIT       = 3'h7;      // Index of final shifted bit
    localparam logic [7:0] REG_ADDR_RST   = 8'h00;     // Register pointer after reset

    // Core sequencing states
    typedef enum logic [2:0] {
        S_SETTLE,
        S_WAIT_LOAD,
        S_FETCH,
        S_DONE,
        S_SLAVE
    } sal_core_e;

    // Link side protocol states
    typedef enum logic [2:0] {
        L_IDLE,
        L_ADDR,
        L_ADDR_ACK,
        L_WR,
        L_WR_ACK,
        L_RD,
        L_RD_ACK
    } sal_link_e;

    // Strap value to seven-bit address
    function automatic logic [6:0] sal_addr_from_strap(input logic [3:0] strap);
        sal_addr_from_strap = BASE_ADDR + {3'h0, strap};
    endfunction : sal_addr_from_strap
endpackage : sal_pkg

// File: design/sal_strap_latch.sv
// Strap latch, boot handover and two-wire slave front end.
// Assumes an external fetch engine does the memory read and a register
// file on the link clock answers i_reg_rdata for o_reg_addr combinationally.
//
// How it works
// [R1] After memory fetch, become bus slave
// [R2] Capture strap pins once after power-up
// [R3] Slave mode, load pin high: address 0x18
// [R4] Host waits until all fetches finish
// [R5] Sixteen addresses from four straps
// [R6] Address is 0x18 plus strap value
// [R7] First byte: seven address bits, direction
// [R8] Direction zero writes, one reads
// [R9] Host builds byte by shifting address
// [R10] Registers reachable over bus after capture
// [R11] Lines only pulled low or released
// [R12] Each device gets distinct strap setting
// [R13] Master mode fetch waits for load low
// [R14] Drive completion output low after fetch
// [R15] Captured address never changes afterwards
`timescale 1ns/1ps
module sal_strap_latch
    import sal_pkg::*;
(
    input  wire logic       i_clock,          // Core clock, 100 MHz
    input  wire logic       i_rst,            // Power-up reset, async high
    input  wire logic       i_link_clock,     // Link sampling clock
    input  wire logic [3:0] i_strap_address_pins,
    input  wire logic       i_bus_mode_select, // High: slave mode
    input  wire logic       i_load_enable_n,  // Fetch permission, low active
    output logic            o_load_done_n,    // Completion, low after fetch
    output logic            o_fetch_start,    // One cycle fetch request
    input  wire logic       i_fetch_done,     // Fetch engine finished
    input  wire logic       i_fetch_scl_low,  // Fetch engine pulls clock
    input  wire logic       i_fetch_sda_low,  // Fetch engine pulls data
    output logic            o_slave_active,   // Slave mode reached
    output logic [6:0]      o_slave_addr,     // Captured seven-bit address
    input  wire logic       i_sda,
    output logic            o_sda_out,
    output logic            o_sda_oe,
    input  wire logic       i_serial_bus_clock_line,
    output logic            o_serial_bus_clock_line_out,
    output logic            o_serial_bus_clock_line_oe,
    output logic [7:0]      o_reg_addr,       // Link clock domain
    output logic [7:0]      o_reg_wdata,
    output logic            o_reg_wr,
    output logic            o_reg_rd,
    input  wire logic [7:0] i_reg_rdata
);
    logic [5:0] pins_s;           // Synchronised straps, mode, load
    sal_core_e  state_q;          // Core sequencer
    logic [1:0] settle_q;         // Settle counter
    logic [3:0] strap_q;          // Captured strap value
    logic       test_q;           // Test address was forced
    logic       latched_q;        // Address captured
    logic [6:0] addr_q;           // Captured address
    logic       fetch_scl_q;      // Fetch drive of clock line
    logic       fetch_sda_q;      // Fetch drive of data line
    logic       slave_en_q;       // Slave enable level to link side

    // Pins from outside pass two flops first
    sal_sync2 #(.W(6)) u_pin_sync (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_d     ({i_load_enable_n, i_bus_mode_select, i_strap_address_pins}),
        .o_q     (pins_s)
    );

    // Core sequencer
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            state_q  <= S_SETTLE;
            settle_q <= '0;
        end else begin
            case (state_q)
                S_SETTLE: begin
                    settle_q <= settle_q + 2'h1;
                    if (settle_q == SETTLE_CYC - 2'h1) begin
                        state_q <= pins_s[4] ? S_SLAVE : S_WAIT_LOAD;
                    end
                end
                // [R13] wait load low
                S_WAIT_LOAD: begin
                    if (!pins_s[5]) begin
                        state_q <= S_FETCH;
                    end
                end
                // [R1] fetch ends, hand over
                S_FETCH: begin
                    if (i_fetch_done) begin
                        state_q <= S_DONE;
                    end
                end
                S_DONE:  state_q <= S_SLAVE;
                default: state_q <= state_q;
            endcase
        end
    end

    // [R2] [R15] one capture, settle only
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            latched_q <= 1'b0;
            strap_q   <= '0;
            test_q    <= 1'b0;
            addr_q    <= '0;
        end else if (state_q == S_SETTLE && settle_q == SETTLE_CYC - 2'h1) begin
            latched_q <= 1'b1;
            strap_q   <= pins_s[3:0];
            test_q    <= pins_s[4] & pins_s[5];
            // [R3] forced test address
            if (pins_s[4] & pins_s[5]) begin
                addr_q <= TEST_WR_BYTE[7:1];
            end else begin
                // [R5] [R6] base plus straps
                addr_q <= sal_addr_from_strap(pins_s[3:0]);
            end
        end
    end

    // Fetch request and bus drive during fetch only
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_fetch_start <= 1'b0;
            fetch_scl_q   <= 1'b0;
            fetch_sda_q   <= 1'b0;
        end else begin
            o_fetch_start <= (state_q == S_WAIT_LOAD) & ~pins_s[5];
            fetch_scl_q   <= (state_q == S_FETCH) & ~i_fetch_done & i_fetch_scl_low;
            fetch_sda_q   <= (state_q == S_FETCH) & ~i_fetch_done & i_fetch_sda_low;
        end
    end

    // [R14] completion low, stays low
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_load_done_n <= 1'b1;
            slave_en_q    <= 1'b0;
        end else begin
            if (state_q == S_FETCH && i_fetch_done) begin
                o_load_done_n <= 1'b0;
            end
            // [R10] bus opens after capture
            if (state_q == S_SLAVE || (state_q == S_FETCH && i_fetch_done)) begin
                slave_en_q <= 1'b1;
            end
        end
    end

    assign o_slave_active = slave_en_q;
    assign o_slave_addr   = addr_q;

    // Link side; address is static once enable is seen here
    logic [1:0] line_s;           // Synchronised clock and data
    logic [1:0] line_low_s;       // Synchronised lines, high while pulled low
    logic       en_l;             // Enable in link domain
    logic       scl_p_q;          // Previous clock sample
    logic       sda_p_q;          // Previous data sample
    sal_link_e  lst_q;            // Link state
    logic [3:0] cnt_q;            // Bit counter
    logic [7:0] sh_q;             // Shift register
    logic       rw_q;             // Direction bit
    logic       first_q;          // Next written byte is pointer
    logic       nack_q;           // Host refused more data
    logic       sda_low_q;        // Slave pulls data low
    logic       scl_rise;
    logic       scl_fall;
    logic       start_c;
    logic       stop_c;

    sal_sync2 #(.W(3)) u_link_sync (
        .i_clock (i_link_clock),
        .i_rst   (i_rst),
        .i_d     ({slave_en_q, ~i_serial_bus_clock_line, ~i_sda}),
        .o_q     ({en_l, line_low_s})
    );
    // Inverted through the flops so reset reads as idle high lines, no false edge
    assign line_s = ~line_low_s;

    // Edge and condition detect
    always_ff @(posedge i_link_clock or posedge i_rst) begin
        if (i_rst) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= line_s[1];
            sda_p_q <= line_s[0];
        end
    end
    assign scl_rise = line_s[1] & ~scl_p_q;
    assign scl_fall = ~line_s[1] & scl_p_q;
    assign start_c  = line_s[1] & scl_p_q & sda_p_q & ~line_s[0];
    assign stop_c   = line_s[1] & scl_p_q & ~sda_p_q & line_s[0];

    // Slave protocol engine
    always_ff @(posedge i_link_clock or posedge i_rst) begin
        if (i_rst) begin
            lst_q       <= L_IDLE;
            cnt_q       <= '0;
            sh_q        <= '0;
            rw_q        <= 1'b0;
            first_q     <= 1'b0;
            nack_q      <= 1'b0;
            sda_low_q   <= 1'b0;
            o_reg_addr  <= REG_ADDR_RST;
            o_reg_wdata <= '0;
            o_reg_wr    <= 1'b0;
            o_reg_rd    <= 1'b0;
        end else begin
            o_reg_wr <= 1'b0;
            o_reg_rd <= 1'b0;
            if (!en_l || stop_c) begin
                // Released outside frames
                lst_q     <= L_IDLE;
                sda_low_q <= 1'b0;
            end else if (start_c) begin
                lst_q     <= L_ADDR;
                cnt_q     <= '0;
                first_q   <= 1'b1;
                sda_low_q <= 1'b0;
            end else begin
                case (lst_q)
                    // [R7] eight bit address byte
                    L_ADDR: begin
                        if (scl_rise) begin
                            sh_q  <= {sh_q[6:0], line_s[0]};
                            cnt_q <= cnt_q + 4'h1;
                        end else if (scl_fall && cnt_q == BYTE_BITS) begin
                            if (sh_q[7:1] == addr_q) begin
                                lst_q     <= L_ADDR_ACK;
                                rw_q      <= sh_q[0];
                                sda_low_q <= 1'b1;
                            end else begin
                                lst_q <= L_IDLE;
                            end
                        end
                    end
                    // [R8] direction picks path
                    L_ADDR_ACK: begin
                        if (scl_fall) begin
                            cnt_q <= '0;
                            if (rw_q) begin
                                lst_q     <= L_RD;
                                sh_q      <= i_reg_rdata;
                                sda_low_q <= ~i_reg_rdata[7];
                                o_reg_rd  <= 1'b1;
                            end else begin
                                lst_q     <= L_WR;
                                sda_low_q <= 1'b0;
                            end
                        end
                    end
                    L_WR: begin
                        if (scl_rise) begin
                            sh_q  <= {sh_q[6:0], line_s[0]};
                            cnt_q <= cnt_q + 4'h1;
                        end else if (scl_fall && cnt_q == BYTE_BITS) begin
                            lst_q     <= L_WR_ACK;
                            sda_low_q <= 1'b1;
                            // [R10] pointer then data
                            if (first_q) begin
                                o_reg_addr <= sh_q;
                            end else begin
                                o_reg_wdata <= sh_q;
                                o_reg_wr    <= 1'b1;
                            end
                        end
                    end
                    L_WR_ACK: begin
                        if (scl_fall) begin
                            lst_q     <= L_WR;
                            cnt_q     <= '0;
                            sda_low_q <= 1'b0;
                            first_q   <= 1'b0;
                            // Pointer byte itself does not advance
                            if (!first_q && cnt_q == BYTE_BITS) begin
                                o_reg_addr <= o_reg_addr + 8'h01;
                            end
                        end
                    end
                    // [R11] zero pulls, one releases
                    L_RD: begin
                        if (scl_fall) begin
                            cnt_q <= cnt_q + 4'h1;
                            if (cnt_q[2:0] == LAST_BIT) begin
                                lst_q     <= L_RD_ACK;
                                sda_low_q <= 1'b0;
                            end else begin
                                sda_low_q <= ~sh_q[6];
                                sh_q      <= {sh_q[6:0], 1'b0};
                            end
                        end
                    end
                    L_RD_ACK: begin
                        if (scl_rise) begin
                            nack_q <= line_s[0];
                            if (!line_s[0]) begin
                                o_reg_addr <= o_reg_addr + 8'h01;
                            end
                        end else if (scl_fall) begin
                            if (nack_q) begin
                                lst_q <= L_IDLE;
                            end else begin
                                lst_q     <= L_RD;
                                cnt_q     <= '0;
                                sh_q      <= i_reg_rdata;
                                sda_low_q <= ~i_reg_rdata[7];
                                o_reg_rd  <= 1'b1;
                            end
                        end
                    end
                    default: lst_q <= L_IDLE;
                endcase
            end
        end
    end

    // [R11] open drain only
    assign o_sda_out                   = 1'b0;
    assign o_sda_oe                    = sda_low_q | fetch_sda_q;
    assign o_serial_bus_clock_line_out = 1'b0;
    assign o_serial_bus_clock_line_oe  = fetch_scl_q;

    // Checks, core domain
    AST_ADDR_FROZEN: assert property (@(posedge i_clock) disable iff (i_rst) // [R15]
        latched_q && $past(latched_q) |-> $stable(addr_q))
        else $error("address changed after capture");
    AST_TEST_ADDR: assert property (@(posedge i_clock) disable iff (i_rst) // [R3]
        latched_q && test_q |-> {addr_q, 1'b0} == TEST_WR_BYTE)
        else $error("test address not forced");
    AST_STRAP_MAP: assert property (@(posedge i_clock) disable iff (i_rst) // [R6]
        latched_q && !test_q |-> addr_q == sal_addr_from_strap(strap_q))
        else $error("address does not follow straps");
    AST_CAPTURE: assert property (@(posedge i_clock) disable iff (i_rst) // [R2]
        state_q == S_SETTLE && settle_q == SETTLE_CYC - 2'h1 |=> latched_q && state_q != S_SETTLE)
        else $error("straps not captured after settle");
    AST_WAIT_LOAD: assert property (@(posedge i_clock) disable iff (i_rst) // [R13]
        state_q == S_WAIT_LOAD && pins_s[5] |=> !o_fetch_start && state_q == S_WAIT_LOAD)
        else $error("fetch began with load high");
    AST_HANDOVER: assert property (@(posedge i_clock) disable iff (i_rst) // [R1]
        state_q == S_FETCH && i_fetch_done |=> slave_en_q && !fetch_scl_q ##1 state_q == S_SLAVE)
        else $error("no handover to slave");
    AST_DONE_LOW: assert property (@(posedge i_clock) disable iff (i_rst) // [R14]
        !o_load_done_n |=> !o_load_done_n && state_q inside {S_DONE, S_SLAVE})
        else $error("completion output not held low");
    // Checks, link domain
    AST_ADDR_ACK: assert property (@(posedge i_link_clock) disable iff (i_rst) // [R7]
        en_l && !start_c && !stop_c && lst_q == L_ADDR && scl_fall && cnt_q == BYTE_BITS
        && sh_q[7:1] == addr_q |=> lst_q == L_ADDR_ACK && sda_low_q)
        else $error("matching address not acknowledged");
    AST_DIR_READ: assert property (@(posedge i_link_clock) disable iff (i_rst) // [R8]
        en_l && !start_c && !stop_c && lst_q == L_ADDR_ACK && scl_fall |=> o_reg_rd == rw_q)
        else $error("direction bit misread");
    AST_IDLE_RELEASE: assert property (@(posedge i_link_clock) disable iff (i_rst) // [R11]
        lst_q == L_IDLE |-> !sda_low_q)
        else $error("data held low while idle");
    COV_HANDOVER: cover property (@(posedge i_clock) disable iff (i_rst)
        state_q == S_FETCH ##1 state_q == S_DONE ##1 state_q == S_SLAVE);
    COV_TEST_ADDR: cover property (@(posedge i_clock) disable iff (i_rst) latched_q && test_q);
    COV_REG_WRITE: cover property (@(posedge i_link_clock) disable iff (i_rst) o_reg_wr);
    COV_REG_READ: cover property (@(posedge i_link_clock) disable iff (i_rst) lst_q == L_RD_ACK);
endmodule : sal_strap_latch

// File: design/sal_sync2.sv
// Two flip-flop level synchroniser of parameterised width.
// Assumes each bit is an independent level or a quasi-static word.
`timescale 1ns/1ps
module sal_sync2 #(
    parameter int W = 1
) (
    input  wire logic         i_clock,
    input  wire logic         i_rst,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    logic [W-1:0] meta_q;   // First stage, read by second stage only

    // Two stage capture
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            meta_q <= '0;
            o_q    <= '0;
        end else begin
            meta_q <= i_d;
            o_q    <= meta_q;
        end
    end
endmodule : sal_sync2

// File: verification/sal_host_model.sv
// Far-side management bus host: open-drain bit-banging master.
// Assumes pull-ups on both wires and a free-running link clock as time base.
`timescale 1ns/1ps
module sal_host_model (
    input  wire logic i_link_clock, // Time base for bus phases
    input  wire logic i_sda,        // Resolved data wire
    output logic      o_sda_pull,   // High pulls data low
    output logic      o_scl_pull    // High pulls clock low
);
    // Both lines released while idle, clock stands high
    initial begin
        o_sda_pull = 1'b0;
        o_scl_pull = 1'b0;
    end

    // One phase is ten link clocks, above the three the slave needs to react
    task automatic tick();
        repeat (10) @(posedge i_link_clock);
        #1;
    endtask : tick

    // pull or release
    // Data moves only a phase after clock falls, so no false start
    task automatic put_bit(input logic b);
        o_sda_pull = !b;
        tick();
        o_scl_pull = 1'b0;
        tick();
        o_scl_pull = 1'b1;
        tick();
    endtask : put_bit

    // Sample data while clock is high
    task automatic get_bit(output logic b);
        o_sda_pull = 1'b0;
        tick();
        o_scl_pull = 1'b0;
        tick();
        b = i_sda;
        o_scl_pull = 1'b1;
        tick();
    endtask : get_bit

    // Start or repeated start: data falls under high clock
    task automatic start();
        o_sda_pull = 1'b0;
        tick();
        o_scl_pull = 1'b0;
        tick();
        o_sda_pull = 1'b1;
        tick();
        o_scl_pull = 1'b1;
        tick();
    endtask : start

    // Stop: data rises under high clock
    task automatic stop();
        o_sda_pull = 1'b1;
        tick();
        o_scl_pull = 1'b0;
        tick();
        o_sda_pull = 1'b0;
        tick();
    endtask : stop

    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i]);
        end
        get_bit(a);
        ack = !a;
    endtask : send_byte

    task automatic recv_byte(input logic ack, output logic [7:0] d);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            get_bit(b);
            d[i] = b;
        end
        put_bit(!ack);
    endtask : recv_byte
endmodule : sal_host_model

// File: verification/sal_strap_latch_tb.sv
// Self-checking bench for the strap latch and bus slave front end.
// Assumes the host model above and a register file answering addr ^ 0x5a.
`timescale 1ns/1ps
module sal_strap_latch_tb;
    import sal_pkg::*;
    logic        clock, rst, link_clock;      // Clocks and reset
    logic [3:0]  strap;                       // Strap pins
    logic        mode, load_n;                // Mode and load permission
    logic        f_done, f_scl, f_sda;        // Fetch engine stand-in
    logic        done_n, f_start, active;     // Boot outputs
    logic [6:0]  slave_addr;                  // Captured address
    logic        sda_out, sda_oe, scl_out, scl_oe;
    logic [7:0]  reg_addr, reg_wdata;         // Register side
    logic        reg_wr, reg_rd;
    logic        h_sda, h_scl;                // Host pulls
    logic [15:0] exp_q[$];                    // Expected {addr,data} writes
    logic [15:0] e;
    int          n_mismatch, check_count, cycles, n_rd;
    // Open-drain wires with pull-ups
    wire         sda_w = !((sda_oe & !sda_out) | h_sda);
    wire         scl_w = !((scl_oe & !scl_out) | h_scl);
    wire [7:0]   rdata = reg_addr ^ 8'h5a;

    sal_strap_latch DUT (.i_clock(clock), .i_rst(rst), .i_link_clock(link_clock),
        .i_strap_address_pins(strap), .i_bus_mode_select(mode), .i_load_enable_n(load_n),
        .o_load_done_n(done_n), .o_fetch_start(f_start), .i_fetch_done(f_done),
        .i_fetch_scl_low(f_scl), .i_fetch_sda_low(f_sda), .o_slave_active(active),
        .o_slave_addr(slave_addr), .i_sda(sda_w), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
        .i_serial_bus_clock_line(scl_w), .o_serial_bus_clock_line_out(scl_out),
        .o_serial_bus_clock_line_oe(scl_oe), .o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata),
        .o_reg_wr(reg_wr), .o_reg_rd(reg_rd), .i_reg_rdata(rdata));
    sal_host_model u_host (.i_link_clock(link_clock), .i_sda(sda_w), .o_sda_pull(h_sda),
        .o_scl_pull(h_scl));

    // Core clock 100 MHz
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // Link clock 125 ns, offset so phases never align
    initial begin
        link_clock = 1'b0;
        #3.3;
        forever #62.5 link_clock = ~link_clock;
    end

    // Compare and count
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test

    // Power-up with given pins; held past two link edges too
    task automatic power_up(input logic m, input logic ld, input logic [3:0] s);
        rst = 1'b1;
        strap = s;
        mode = m;
        load_n = ld;
        repeat (8) @(negedge clock);
        repeat (2) @(posedge link_clock);
        @(negedge clock);
        rst = 1'b0;
        repeat (12) @(negedge clock);
    endtask : power_up

    // Send one byte and compare the acknowledge
    task automatic tx(input logic [7:0] b, input logic exp_ack);
        logic ak;
        u_host.send_byte(b, ak);
        chk("ack", {7'h00, exp_ack}, {7'h00, ak});
    endtask : tx

    // Write pointer then data, noting each expected register write
    task automatic wr2(input logic [6:0] a7, input logic [7:0] p, input int nd);
        logic [7:0] d;
        u_host.start();
        tx({a7, 1'b0}, 1'b1);
        tx(p, 1'b1);
        for (int i = 0; i < nd; i++) begin
            d = 8'($urandom);
            exp_q.push_back({p + 8'(i), d});
            tx(d, 1'b1);
        end
        u_host.stop();
    endtask : wr2

    // Result watcher: each write pulse takes the oldest note; read loads counted
    always @(negedge link_clock) begin
        if (reg_rd === 1'b1) begin
            n_rd++;
        end
        if (reg_wr === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk("stray write", 8'h00, 8'hff);
            end else begin
                e = exp_q.pop_front();
                chk("reg addr", e[15:8], reg_addr);
                chk("reg data", e[7:0], reg_wdata);
            end
        end
    end

    // Hang guard, about twice the expected run
    always @(posedge clock) begin
        cycles++;
        if (cycles == 90000) begin
            n_mismatch++;
            stop_test();
        end
    end

    initial begin
        logic [7:0] p, rd;
        logic [6:0] a7;
        logic [3:0] s;
        int         n;
        {rst, strap, mode, load_n, f_done, f_scl, f_sda} = '0;
        void'($urandom(4));
        s = 4'(1 + $urandom % 15);
        // Test address whatever the straps say
        power_up(1'b1, 1'b1, s);
        chk("test addr", {1'b0, TEST_WR_BYTE[7:1]}, {1'b0, slave_addr});
        strap = ~s;
        load_n = 1'b0;
        repeat (20) @(negedge clock);
        chk("addr held", {1'b0, TEST_WR_BYTE[7:1]}, {1'b0, slave_addr});
        // Every strap combination
        for (int i = 0; i < 16; i++) begin
            power_up(1'b1, 1'b0, 4'(i));
            chk("strap addr", {1'b0, BASE_ADDR} + 8'(i), {1'b0, slave_addr});
        end
        // Slave traffic at a random strap; host holds off until active
        power_up(1'b1, 1'b0, s);
        for (n = 0; n < 50 && active !== 1'b1; n++) @(negedge clock);
        chk("slave active", 8'h01, {7'h00, active});
        repeat (30) @(negedge clock);
        a7 = BASE_ADDR + {3'h0, s};
        p = 8'($urandom);
        wr2(a7, p, 2);
        // Pointer then repeated start read
        u_host.start();
        tx({a7, 1'b0}, 1'b1);
        tx(p, 1'b1);
        u_host.start();
        tx({a7, 1'b1}, 1'b1);
        u_host.recv_byte(1'b1, rd);
        chk("read 0", p ^ 8'h5a, rd);
        u_host.recv_byte(1'b0, rd);
        chk("read 1", (p + 8'h01) ^ 8'h5a, rd);
        u_host.stop();
        // Another device's address draws no answer
        u_host.start();
        tx({a7 + 7'h01, 1'b0}, 1'b0);
        u_host.stop();
        // Master mode: no fetch before load goes low
        power_up(1'b0, 1'b1, ~s);
        n = 0;
        repeat (60) begin
            @(negedge clock);
            n += int'(f_start === 1'b1);
        end
        chk("early fetch", 8'h00, 8'(n));
        chk("early slave", 8'h00, {7'h00, active});
        load_n = 1'b0;
        for (n = 0; n < 20 && f_start !== 1'b1; n++) @(negedge clock);
        chk("fetch start", 8'h01, {7'h00, f_start});
        f_scl = 1'b1;
        f_sda = 1'b1;
        repeat (4) @(negedge clock);
        chk("fetch oe", 8'h03, {4'h0, scl_out, sda_out, scl_oe, sda_oe});
        chk("done early", 8'h01, {7'h00, done_n});
        // Fetch engine keeps pulling: the design itself must let go
        f_done = 1'b1;
        repeat (3) @(negedge clock);
        f_done = 1'b0;
        chk("done", 8'h00, {7'h00, done_n});
        chk("handover", 8'h01, {7'h00, active});
        chk("released", 8'h00, {6'h00, scl_oe, sda_oe});
        f_scl = 1'b0;
        f_sda = 1'b0;
        load_n = 1'b1;
        strap = s;
        repeat (30) @(negedge clock);
        a7 = BASE_ADDR + {3'h0, ~s};
        chk("master addr", {1'b0, a7}, {1'b0, slave_addr});
        wr2(a7, 8'($urandom), 1);
        repeat (50) @(negedge clock);
        chk("writes left", 8'h00, 8'(exp_q.size()));
        chk("read loads", 8'h02, 8'(n_rd));
        stop_test();
    end
endmodule : sal_strap_latch_tb
